//--- rtl/vcac_arb_ctrl.sv
// Arbitration control, status and channel-zero capability registers
`timescale 1ns/1ps
`include "vcac_regs.svh"
module vcac_arb_ctrl #(
  parameter int PHASES = `VCAC_TABLE_PHASES,
  parameter int ENTRY_W = `VCAC_TABLE_ENTRY_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Extended configuration access
  input wire logic [11:0] i_cfg_addr,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  output logic o_cfg_hit,
  // Staged table in configuration space
  input wire logic i_staged_table_write,
  input wire logic [PHASES*ENTRY_W-1:0] i_staged_table,
  input wire logic [2:0] i_low_priority_count,
  // Arbiter side
  output logic [2:0] o_arb_scheme,
  output logic o_arb_use_table,
  output logic [PHASES*ENTRY_W-1:0] o_working_table,
  output logic o_table_copy_busy,
  output logic [7:0] o_channel_scheme_support
);
  vcac_copy_if cp_if ();

  logic [2:0] scheme_r;
  logic pending_r;
  logic mod_in_copy_r;
  logic load_req_r;
  logic start_r;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic hit_r;
  logic [2:0] scheme_nxt;
  logic pending_nxt;
  logic mod_in_copy_nxt;
  logic load_req_nxt;
  logic start_nxt;

  // Decode
  wire [9:0] dw_addr = i_cfg_addr[11:2];
  wire sel_cs = (dw_addr == `VCAC_DW_CTRL_STAT);
  wire sel_cap = (dw_addr == `VCAC_DW_RCAP);
  wire wr_ctrl_lo = i_cfg_wr & sel_cs & i_cfg_be[0];
  wire load_wr = wr_ctrl_lo & i_cfg_wdata[`VCAC_CTRL_LOAD_BIT];
  wire [2:0] sel_wdata =
    i_cfg_wdata[`VCAC_CTRL_SEL_MSB:`VCAC_CTRL_SEL_LSB];

  // Read images; only the select field and pending bit are live
  wire [15:0] ctrl_img = {12'h000, scheme_r, 1'b0};
  wire [15:0] stat_img = {15'h0000, pending_r};
  // Every capability field is fixed; nothing here is writable
  wire [31:0] cap_img = `VCAC_RCAP_VAL;
  wire [31:0] rd_mux = sel_cs ? {stat_img, ctrl_img} :
                       sel_cap ? cap_img : 32'h00000000;

  // Scheme select: reserved codes are stored and driven to the arbiter on o_arb_scheme as written
  always_comb begin
    scheme_nxt = wr_ctrl_lo ? sel_wdata : scheme_r;
  end

  // Load requests arriving mid-copy are held and replayed afterwards
  always_comb begin
    load_req_nxt = load_req_r;
    start_nxt = 1'b0;
    if (load_wr) begin
      load_req_nxt = 1'b1;
    end
    if (load_req_nxt && !cp_if.busy && !start_r) begin
      start_nxt = 1'b1;
      load_req_nxt = 1'b0;
    end
  end

  // Modification during a copy may miss entries, so keep pending set
  always_comb begin
    mod_in_copy_nxt = mod_in_copy_r;
    if (cp_if.done) begin
      mod_in_copy_nxt = 1'b0;
    end
    if (i_staged_table_write && (cp_if.busy || start_r)) begin
      mod_in_copy_nxt = 1'b1;
    end
  end

  // Set wins over clear
  always_comb begin
    pending_nxt = pending_r;
    if (cp_if.done && !mod_in_copy_r && !load_req_r) begin
      pending_nxt = 1'b0;
    end
    if (i_staged_table_write) begin
      pending_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scheme_r <= `VCAC_SEL_RST;
      pending_r <= 1'b0;
      mod_in_copy_r <= 1'b0;
      load_req_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      scheme_r <= scheme_nxt;
      pending_r <= pending_nxt;
      mod_in_copy_r <= mod_in_copy_nxt;
      load_req_r <= load_req_nxt;
      start_r <= start_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_r <= 32'h00000000;
      rvalid_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      rdata_r <= i_cfg_rd ? rd_mux : 32'h00000000;
      rvalid_r <= i_cfg_rd;
      hit_r <= i_cfg_rd & (sel_cs | sel_cap);
    end
  end

  assign cp_if.start = start_r;

  vcac_table_copier #(
    .PHASES(PHASES),
    .ENTRY_W(ENTRY_W)
  ) u_copier (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .cp(cp_if),
    .i_staged_table(i_staged_table),
    .o_working_table(o_working_table)
  );

  assign o_cfg_rdata = rdata_r;
  assign o_cfg_rvalid = rvalid_r;
  assign o_cfg_hit = hit_r;
  assign o_arb_scheme = scheme_r;
  assign o_arb_use_table =
    (scheme_r == vcac_pkg::VCAC_SCHEME_WRR32);
  assign o_table_copy_busy = cp_if.busy;
  // No low-priority channel means the table is only a scratch pad
  assign o_channel_scheme_support = (i_low_priority_count == 3'h0) ?
    `VCAC_CH_CAP_NONE : `VCAC_CH_CAP_FULL;
endmodule

//--- rtl/vcac_copy_if.sv
// Handshake between the register bank and the table copier
`timescale 1ns/1ps
interface vcac_copy_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport copier (input start, output busy, output done);
endinterface

//--- rtl/vcac_pkg.sv
// Types shared by the arbitration control register bank
package vcac_pkg;
  typedef enum logic [2:0] {
    VCAC_SCHEME_RR = 3'h0,
    VCAC_SCHEME_WRR32 = 3'h1
  } vcac_scheme_t;

  typedef enum logic [2:0] {
    VCAC_CP_IDLE = 3'h1,
    VCAC_CP_COPY = 3'h2,
    VCAC_CP_DONE = 3'h4
  } vcac_copy_state_t;
endpackage

//--- rtl/vcac_regs.svh
// Register offsets, field positions, reset and fixed values
`ifndef VCAC_REGS_SVH
`define VCAC_REGS_SVH
`define VCAC_CTRL_OFS 12'h15c
`define VCAC_STAT_OFS 12'h15e
`define VCAC_RCAP_OFS 12'h160
`define VCAC_DW_CTRL_STAT 10'h057
`define VCAC_DW_RCAP 10'h058
`define VCAC_CTRL_LOAD_BIT 0
`define VCAC_CTRL_SEL_LSB 1
`define VCAC_CTRL_SEL_MSB 3
`define VCAC_STAT_PEND_BIT 0
`define VCAC_CTRL_RST 16'h0000
`define VCAC_STAT_RST 16'h0000
`define VCAC_SEL_RST 3'h0
`define VCAC_RCAP_VAL 32'h00000001
`define VCAC_CH_CAP_FULL 8'h03
`define VCAC_CH_CAP_NONE 8'h00
`define VCAC_TABLE_PHASES 32
`define VCAC_TABLE_ENTRY_W 4
`endif

//--- rtl/vcac_table_copier.sv
// Copies the staged arbitration table into the working table
`timescale 1ns/1ps
`include "vcac_regs.svh"
module vcac_table_copier #(
  parameter int PHASES = `VCAC_TABLE_PHASES,
  parameter int ENTRY_W = `VCAC_TABLE_ENTRY_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Handshake
  vcac_copy_if.copier cp,
  // Tables
  input wire logic [PHASES*ENTRY_W-1:0] i_staged_table,
  output logic [PHASES*ENTRY_W-1:0] o_working_table
);
  localparam int IW = (PHASES > 1) ? $clog2(PHASES) : 1;
  localparam logic [IW-1:0] LAST = IW'(PHASES - 1);

  vcac_pkg::vcac_copy_state_t state_r;
  vcac_pkg::vcac_copy_state_t state_nxt;
  logic [IW-1:0] idx_r;
  logic [ENTRY_W-1:0] work_r [PHASES];
  wire copying = (state_r == vcac_pkg::VCAC_CP_COPY);
  wire [ENTRY_W-1:0] staged_entry = i_staged_table[idx_r*ENTRY_W +: ENTRY_W];

  assign cp.busy = (state_r != vcac_pkg::VCAC_CP_IDLE);
  assign cp.done = (state_r == vcac_pkg::VCAC_CP_DONE);

  always_comb begin
    case (state_r)
      vcac_pkg::VCAC_CP_IDLE:
        state_nxt = cp.start ? vcac_pkg::VCAC_CP_COPY : vcac_pkg::VCAC_CP_IDLE;
      vcac_pkg::VCAC_CP_COPY:
        state_nxt = (idx_r == LAST) ? vcac_pkg::VCAC_CP_DONE
                                    : vcac_pkg::VCAC_CP_COPY;
      vcac_pkg::VCAC_CP_DONE: state_nxt = vcac_pkg::VCAC_CP_IDLE;
      default: state_nxt = vcac_pkg::VCAC_CP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= vcac_pkg::VCAC_CP_IDLE;
      idx_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= copying ? idx_r + IW'(1) : '0;
    end
  end

  // One entry per cycle keeps the copy to a single narrow mux
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < PHASES; i++) begin
        work_r[i] <= '0;
      end
    end else if (copying) begin
      work_r[idx_r] <= staged_entry;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : g_out
      assign o_working_table[g*ENTRY_W +: ENTRY_W] = work_r[g];
    end
  endgenerate
endmodule

//--- test/tb.sv
// Self-checking bench for the arbitration control register bank
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic h;
  } vcac_row_t;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [11:0] i_cfg_addr = 12'h000;
  logic i_cfg_wr = 1'b0;
  logic i_cfg_rd = 1'b0;
  logic [3:0] i_cfg_be = 4'hf;
  logic [31:0] i_cfg_wdata = 32'h0;
  logic i_staged_table_write = 1'b0;
  logic [127:0] i_staged_table = 128'h0;
  logic [2:0] i_low_priority_count = 3'h1;
  logic [31:0] o_cfg_rdata;
  logic o_cfg_rvalid, o_cfg_hit, o_arb_use_table, o_table_copy_busy;
  logic [2:0] o_arb_scheme;
  logic [127:0] o_working_table;
  logic [7:0] o_channel_scheme_support;
  int num_errors = 0;
  int n_tests = 0;
  int k;
  vcac_row_t rows [5];
  always #25 i_clk = ~i_clk;
  vcac_arb_ctrl dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_cfg_addr(i_cfg_addr), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
    .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
    .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
    .o_cfg_hit(o_cfg_hit), .i_staged_table_write(i_staged_table_write),
    .i_staged_table(i_staged_table),
    .i_low_priority_count(i_low_priority_count),
    .o_arb_scheme(o_arb_scheme), .o_arb_use_table(o_arb_use_table),
    .o_working_table(o_working_table),
    .o_table_copy_busy(o_table_copy_busy),
    .o_channel_scheme_support(o_channel_scheme_support));
  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t mismatch in check %0d", $time, n_tests);
    end
  endtask
  // Write strobe held for exactly one taken edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_cfg_addr <= a;
    i_cfg_wdata <= d;
    i_cfg_wr <= 1'b1;
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
  endtask
  // Answer is registered on the taken edge itself and stands one cycle
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_cfg_addr <= a;
    i_cfg_rd <= 1'b1;
    @(posedge i_clk);
    i_cfg_rd <= 1'b0;
    #1;
    chk(o_cfg_rvalid, 1'b1);
    chk(o_cfg_rdata, e);
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    rows[0] = '{12'h15c, 32'hffff_fff2, 32'h0000_0002, 1'b1};
    rows[1] = '{12'h15c, 32'h0000_0000, 32'h0000_0000, 1'b1};
    rows[2] = '{12'h160, 32'hffff_ffff, 32'h0000_0001, 1'b1};
    rows[3] = '{12'h164, 32'hffff_ffff, 32'h0000_0000, 1'b0};
    rows[4] = '{12'h15c, 32'h0000_0102, 32'h0000_0002, 1'b1};
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(12'h15c, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
      chk(o_cfg_rdata, rows[i].e);
      chk(o_arb_scheme, rows[i].e[3:1]);
      chk(o_cfg_hit, rows[i].h);
      chk(o_arb_use_table, rows[i].e[1]);
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge i_clk);
      i_low_priority_count <= c[2:0];
      #1;
      chk(o_channel_scheme_support, (c == 0) ? 8'h00 : 8'h03);
    end
    $display("Register rows done");
    @(posedge i_clk);
    i_staged_table <= 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    i_staged_table_write <= 1'b1;
    @(posedge i_clk);
    i_staged_table_write <= 1'b0;
    rd(12'h15c, 32'h0001_0002);
    wr(12'h15c, 32'h0000_0003);
    rd(12'h15c, 32'h0001_0002);
    chk(o_table_copy_busy, 1'b1);
    // Bounded so a stuck copier ends the run instead of hanging it
    for (k = 0; k < 60 && o_table_copy_busy !== 1'b0; k++) begin
      @(posedge i_clk);
      #1;
    end
    chk(k < 60, 1'b1);
    rd(12'h15c, 32'h0000_0002);
    chk(o_working_table, i_staged_table);
    $display("Table load done");
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(12'h15c, 32'h0);
    chk(o_working_table, 128'h0);
    $display("Mid-run reset done");
    end_sim();
  end
endmodule

//--- test/vcac_props_properties.sv
// Port checks for the arbitration control register bank
`timescale 1ns/1ps
module vcac_props #(
  parameter int PHASES = 32,
  parameter int ENTRY_W = 4
) (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_cfg_addr,
  input wire logic i_cfg_wr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_cfg_rvalid,
  // Arbiter side
  input wire logic [2:0] o_arb_scheme,
  input wire logic o_arb_use_table,
  input wire logic o_table_copy_busy,
  input wire logic [2:0] i_low_priority_count,
  input wire logic [7:0] o_channel_scheme_support
);
  logic [9:0] dw_r;
  always_ff @(posedge i_clk) begin
    dw_r <= i_cfg_addr[11:2];
  end
  wire c_rd = o_cfg_rvalid && dw_r == 10'h057;
  wire k_rd = o_cfg_rvalid && dw_r == 10'h058;
  wire ld = i_cfg_wr && i_cfg_be[0] && i_cfg_wdata[0];
  wire ld_ok = ld && i_cfg_addr[11:2] == 10'h057 && !o_table_copy_busy;
  wire [7:0] ch_exp = (i_low_priority_count == 3'h0) ? 8'h00 : 8'h03;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_ctl; c_rd |-> o_cfg_rdata[15:4] == 12'h000; endproperty
  a_ctl: assert property (p_ctl) else $error("ctrl spare bits");
  property p_ld0; c_rd |-> !o_cfg_rdata[0]; endproperty
  a_ld0: assert property (p_ld0) else $error("load bit read");
  property p_st; c_rd |-> o_cfg_rdata[31:17] == 15'h0000; endproperty
  a_st: assert property (p_st) else $error("status spare");
  property p_cap; k_rd |-> o_cfg_rdata == 32'h00000001; endproperty
  a_cap: assert property (p_cap) else $error("cap value");
  property p_use; o_arb_use_table == (o_arb_scheme == 3'h1); endproperty
  a_use: assert property (p_use) else $error("table use");
  property p_ch; o_channel_scheme_support == ch_exp; endproperty
  a_ch: assert property (p_ch) else $error("channel schemes");
  property p_cp; ld_ok |=> ##2 o_table_copy_busy [*8]; endproperty
  a_cp: assert property (p_cp) else $error("copy start");
  property p_rst; $fell(i_sys_rst) |-> o_arb_scheme == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("select reset");
endmodule
bind vcac_arb_ctrl vcac_props #(.PHASES(PHASES), .ENTRY_W(ENTRY_W)) u_p (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cfg_addr(i_cfg_addr),
  .i_cfg_wr(i_cfg_wr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
  .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
  .o_arb_scheme(o_arb_scheme), .o_arb_use_table(o_arb_use_table),
  .o_table_copy_busy(o_table_copy_busy),
  .i_low_priority_count(i_low_priority_count),
  .o_channel_scheme_support(o_channel_scheme_support));
